// ===== common/core_ptr_pkg.sv
// package: constants for the pointer, table and stack unit
package core_ptr_pkg;
  // ==========================================================
  // register offsets in bank 0
  localparam logic [7:0] ADDR_FIRST_PTR_LOW = 8'h80;
  localparam logic [7:0] ADDR_FIRST_PTR_HIGH = 8'h81;
  localparam logic [7:0] ADDR_TABLE_HIGH = 8'h82;
  localparam logic [7:0] ADDR_SECOND_PTR_LOW = 8'h83;
  localparam logic [7:0] ADDR_SECOND_PTR_HIGH = 8'h84;
  localparam logic [7:0] ADDR_STACK_PTR_CTL = 8'hDF;
  localparam logic [7:0] ADDR_FIRST_WINDOW = 8'hE6;
  localparam logic [7:0] ADDR_SECOND_WINDOW = 8'hE7;
  localparam logic [7:0] ADDR_STACK_BASE = 8'hF0;
  localparam logic [7:0] ADDR_WORK_LAST = 8'h87;
  // ==========================================================
  // field positions and reset values
  localparam int GIE_BIT = 7;
  localparam int PC_W = 14;
  localparam int PC_HIGH_W = 6;
  localparam int STACK_DEPTH = 8;
  localparam logic [2:0] STACK_LEVEL_RESET = 3'h7;
  localparam logic GIE_RESET = 1'b0;
  localparam logic [13:0] STACK_ENTRY_RESET = 14'h0000;
  // ==========================================================
  // factory options
  typedef enum logic [2:0] {
    CLK_INTERNAL_FAST_RC = 3'h0,
    CLK_INTERNAL_FAST_RC_TICK = 3'h1,
    CLK_OUTSIDE_RC_OSC = 3'h2,
    CLK_XTAL_LOW = 3'h3,
    CLK_XTAL_HIGH = 3'h4,
    CLK_XTAL_STD = 3'h5
  } clk_src_e;
  typedef enum logic [1:0] {
    WDT_ALWAYS_ON = 2'h0,
    WDT_ENABLE = 2'h1,
    WDT_DISABLE = 2'h2
  } wdt_mode_e;
  // instruction cycle dividers 2, 4, 8, 16
  localparam logic [4:0] CYCLE_DIV_2 = 5'h02;
  localparam logic [4:0] CYCLE_DIV_4 = 5'h04;
  localparam logic [4:0] CYCLE_DIV_8 = 5'h08;
  localparam logic [4:0] CYCLE_DIV_16 = 5'h10;
endpackage : core_ptr_pkg

// ===== rtl/core_pointer_stack_unit.sv
// design: working/pointer registers, table read, return stack, options
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - first pair gives bank and location
// RQ2 - second pair gives bank and location
// RQ3 - table read addresses rom by second pair
// RQ4 - table word high to table reg, low accumulator
// RQ5 - pointer registers 8-bit, read/write, no reset
// RQ6 - immediate loads only to 0x80..0x87
// RQ7 - direct move accumulator to/from bank 0
// RQ8 - eight-level stack on call and interrupt
// RQ9 - 3-bit pointer, 14-bit entries
// RQ10 - push decrements, pop increments pointer
// RQ11 - pushes fill 0..7; ninth push overflows
// RQ12 - both return ops pop into program counter
// RQ13 - stack mapped in bank 0, bytes reset zero
// RQ14 - pointer bit 7 is interrupt enable, reset 0
// RQ15 - software initialises pointer to all ones
// RQ16 - option picks clock source; rc frees pins
// RQ17 - option picks cycle of 2/4/8/16 clocks
// RQ18 - option picks watchdog mode
// RQ19 - reset option: falling pin edge resets
// RQ20 - input option: pin is input, no pull-up
// RQ21 - security option blocks full rom readout
// RQ22 - pushed counter is 14 bits, 6 high 8 low
// RQ23 - window registers redirect to pointed ram byte
module core_pointer_stack_unit (
  input wire logic i_mclk,
  input wire logic i_srst,
  // register access from the core
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_imm,
  output logic [7:0] o_reg_rdata,
  output logic o_imm_refused,
  // direct and indirect ram port
  output logic [15:0] o_ram_addr,
  output logic o_ram_we,
  output logic o_ram_re,
  output logic [7:0] o_ram_wdata,
  input wire logic [7:0] i_ram_rdata,
  // stack operations
  input wire logic i_call_push,
  input wire logic i_irq_push,
  input wire logic i_sub_exit,
  input wire logic i_irq_exit,
  input wire logic [core_ptr_pkg::PC_W-1:0] i_pc,
  output logic [core_ptr_pkg::PC_W-1:0] o_pop_pc,
  output logic o_pop_valid,
  output logic o_stack_overflow,
  output logic o_global_irq_enable,
  // rom table read
  input wire logic i_rom_table_read,
  input wire logic i_rom_external_dump,
  output logic [15:0] o_rom_addr,
  input wire logic [15:0] i_rom_data,
  output logic [7:0] o_acc_data,
  output logic o_acc_load,
  // factory options
  input wire core_ptr_pkg::clk_src_e i_opt_clk_src,
  input wire logic [1:0] i_opt_cycle_sel,
  input wire core_ptr_pkg::wdt_mode_e i_opt_wdt,
  input wire logic i_opt_reset_pin,
  input wire logic i_opt_security,
  input wire logic i_power_down,
  input wire logic i_shared_pin,
  output logic o_osc_pins_gpio,
  output logic o_xout_gpio,
  output logic o_rtc_tick_en,
  output logic [4:0] o_cycle_div,
  output logic o_wdt_run,
  output logic o_ext_reset,
  output logic o_input_only_pin,
  output logic o_input_pullup_en,
  output logic o_rom_dump_block
);
  import core_ptr_pkg::*;

  // ==========================================================
  // working and pointer registers
  // no reset on purpose: software must load them before use
  logic [7:0] first_pointer_low_r;
  logic [7:0] first_pointer_high_r;
  logic [7:0] table_high_byte_r;
  logic [7:0] second_pointer_low_r;
  logic [7:0] second_pointer_high_r;
  logic [2:0] stack_level_bits_r;
  logic [2:0] stack_level_bits_nxt;
  logic global_irq_enable_r;
  logic [PC_W-1:0] stack_mem_r [STACK_DEPTH];
  logic [3:0] depth_r;
  logic [3:0] depth_nxt;
  logic overflow_r;
  logic [PC_W-1:0] pop_pc_r;
  logic pop_valid_r;
  logic [7:0] acc_data_r;
  logic acc_load_r;
  logic pin_prev_r;
  logic ext_reset_r;

  wire is_work = (i_reg_addr >= ADDR_FIRST_PTR_LOW) && (i_reg_addr <= ADDR_WORK_LAST);
  wire imm_ok = !i_reg_imm || is_work; // RQ6
  wire wr = i_reg_we && imm_ok;
  wire hit_first_window = (i_reg_addr == ADDR_FIRST_WINDOW);
  wire hit_second_window = (i_reg_addr == ADDR_SECOND_WINDOW);
  wire hit_stack = (i_reg_addr[7:4] == ADDR_STACK_BASE[7:4]);
  wire [2:0] stk_idx = 3'(7 - i_reg_addr[3:1]);
  wire stk_high = i_reg_addr[0];
  wire [15:0] first_addr = {first_pointer_high_r, first_pointer_low_r}; // RQ1
  wire [15:0] second_addr = {second_pointer_high_r, second_pointer_low_r}; // RQ2
  wire any_push = i_call_push || i_irq_push; // RQ8
  wire any_pop = i_sub_exit || i_irq_exit; // RQ12
  wire [2:0] push_idx = 3'(stack_level_bits_r - 3'h1);
  wire [2:0] pop_idx = 3'(stack_level_bits_r + 3'h1);
  // a push fills the entry at the current level: level 7 fills entry 0
  wire [2:0] push_entry = 3'(7 - stack_level_bits_r); // RQ11
  // a pop reads the entry one level up, the one the newest push filled
  wire [2:0] pop_entry = 3'(7 - pop_idx); // RQ12
  wire is_mapped = hit_stack || (i_reg_addr == ADDR_STACK_PTR_CTL) ||
                   (i_reg_addr >= ADDR_FIRST_PTR_LOW && i_reg_addr <= ADDR_SECOND_PTR_HIGH);
  wire ram_path = !is_mapped && !is_work;

  // ==========================================================
  // write decode; a refused immediate write reaches none of these
  wire wr_first_low = wr && (i_reg_addr == ADDR_FIRST_PTR_LOW);
  wire wr_first_high = wr && (i_reg_addr == ADDR_FIRST_PTR_HIGH);
  wire wr_table_high = wr && (i_reg_addr == ADDR_TABLE_HIGH);
  wire wr_second_low = wr && (i_reg_addr == ADDR_SECOND_PTR_LOW);
  wire wr_second_high = wr && (i_reg_addr == ADDR_SECOND_PTR_HIGH);
  wire wr_stack_ctl = wr && (i_reg_addr == ADDR_STACK_PTR_CTL);
  wire pop_take = any_pop && !any_push;
  wire push_full = any_push && (depth_r >= 4'(STACK_DEPTH));
  // stack bytes as the bus sees them; unused high bits read as zero
  wire [PC_W-1:0] stk_word = stack_mem_r[stk_idx];
  wire [7:0] stk_byte = stk_high ? {2'h0, stk_word[13:8]} : stk_word[7:0];
  wire [7:0] stk_ctl_byte = {global_irq_enable_r, 4'h0, stack_level_bits_r};

  // ==========================================================
  // ram port: window redirect, else direct bank-0 move
  always_comb begin
    o_ram_addr = {8'h00, i_reg_addr}; // RQ7
    if (hit_first_window) begin
      o_ram_addr = first_addr; // RQ23
    end else if (hit_second_window) begin
      o_ram_addr = second_addr; // RQ23
    end
  end
  assign o_ram_we = wr && ram_path;
  assign o_ram_re = i_reg_re && ram_path;
  assign o_ram_wdata = i_reg_wdata;
  assign o_imm_refused = i_reg_we && !imm_ok;

  // ==========================================================
  // register read mux
  always_comb begin
    o_reg_rdata = i_ram_rdata;
    if (hit_stack) begin
      o_reg_rdata = stk_byte; // RQ13
    end else begin
      unique case (i_reg_addr)
        ADDR_FIRST_PTR_LOW: o_reg_rdata = first_pointer_low_r; // RQ5
        ADDR_FIRST_PTR_HIGH: o_reg_rdata = first_pointer_high_r;
        ADDR_TABLE_HIGH: o_reg_rdata = table_high_byte_r;
        ADDR_SECOND_PTR_LOW: o_reg_rdata = second_pointer_low_r;
        ADDR_SECOND_PTR_HIGH: o_reg_rdata = second_pointer_high_r;
        ADDR_STACK_PTR_CTL: o_reg_rdata = stk_ctl_byte;
        default: o_reg_rdata = i_ram_rdata;
      endcase
    end
  end

  // ==========================================================
  // pointer/working registers, table read result
  always_ff @(posedge i_mclk) begin
    if (wr_first_low) begin
      first_pointer_low_r <= i_reg_wdata; // RQ5
    end
  end

  always_ff @(posedge i_mclk) begin
    if (wr_first_high) begin
      first_pointer_high_r <= i_reg_wdata; // RQ5
    end
  end

  always_ff @(posedge i_mclk) begin
    if (wr_second_low) begin
      second_pointer_low_r <= i_reg_wdata; // RQ5
    end
  end

  always_ff @(posedge i_mclk) begin
    if (wr_second_high) begin
      second_pointer_high_r <= i_reg_wdata; // RQ5
    end
  end

  // a table read outranks a bus write to the same register in one cycle
  always_ff @(posedge i_mclk) begin
    if (i_rom_table_read) begin
      table_high_byte_r <= i_rom_data[15:8]; // RQ4
    end else if (wr_table_high) begin
      table_high_byte_r <= i_reg_wdata;
    end
  end

  assign o_rom_addr = second_addr; // RQ3

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      acc_data_r <= 8'h00;
      acc_load_r <= 1'b0;
    end else begin
      acc_load_r <= i_rom_table_read;
      if (i_rom_table_read) begin
        acc_data_r <= i_rom_data[7:0]; // RQ4
      end
    end
  end

  // ==========================================================
  // return stack
  // a push and a pop in the same cycle: push wins, pop is dropped
  always_comb begin
    stack_level_bits_nxt = stack_level_bits_r;
    depth_nxt = depth_r;
    if (any_push) begin
      stack_level_bits_nxt = push_idx; // RQ10
      depth_nxt = (depth_r == 4'(STACK_DEPTH + 1)) ? depth_r : 4'(depth_r + 4'h1);
    end else if (any_pop) begin
      stack_level_bits_nxt = pop_idx; // RQ10
      depth_nxt = (depth_r == 4'h0) ? depth_r : 4'(depth_r - 4'h1);
    end else if (wr_stack_ctl) begin
      stack_level_bits_nxt = i_reg_wdata[2:0];
      depth_nxt = 4'(3'h7 - i_reg_wdata[2:0]);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      stack_level_bits_r <= STACK_LEVEL_RESET;
      depth_r <= 4'h0;
    end else begin
      stack_level_bits_r <= stack_level_bits_nxt; // RQ9
      depth_r <= depth_nxt;
    end
  end

  // overflow is sticky; a push that overflows outranks a clearing write
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      overflow_r <= 1'b0;
    end else if (push_full) begin
      overflow_r <= 1'b1; // RQ11
    end else if (wr_stack_ctl) begin
      overflow_r <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      global_irq_enable_r <= GIE_RESET; // RQ14
    end else if (wr_stack_ctl) begin
      global_irq_enable_r <= i_reg_wdata[GIE_BIT]; // RQ14
    end
  end

  // an overflowing push still lands, overwriting the oldest entry
  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : g_stack
      wire push_here = any_push && (push_entry == 3'(g)); // RQ11
      wire wr_here = wr && hit_stack && (stk_idx == 3'(g));
      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          stack_mem_r[g] <= STACK_ENTRY_RESET; // RQ13
        end else if (push_here) begin
          stack_mem_r[g] <= i_pc; // RQ22
        end else if (wr_here && stk_high) begin
          stack_mem_r[g][13:8] <= i_reg_wdata[PC_HIGH_W-1:0];
        end else if (wr_here) begin
          stack_mem_r[g][7:0] <= i_reg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pop_pc_r <= 14'h0000;
      pop_valid_r <= 1'b0;
    end else begin
      pop_valid_r <= pop_take;
      if (pop_take) begin
        pop_pc_r <= stack_mem_r[pop_entry]; // RQ12
      end
    end
  end

  assign o_pop_pc = pop_pc_r;
  assign o_pop_valid = pop_valid_r;
  assign o_stack_overflow = overflow_r;
  assign o_global_irq_enable = global_irq_enable_r;
  assign o_acc_data = acc_data_r;
  assign o_acc_load = acc_load_r;

  // ==========================================================
  // factory options
  wire src_internal_rc = (i_opt_clk_src == CLK_INTERNAL_FAST_RC) ||
                         (i_opt_clk_src == CLK_INTERNAL_FAST_RC_TICK);
  wire src_outside_rc = (i_opt_clk_src == CLK_OUTSIDE_RC_OSC);
  assign o_osc_pins_gpio = src_internal_rc; // RQ16
  assign o_xout_gpio = src_internal_rc || src_outside_rc;
  assign o_rtc_tick_en = (i_opt_clk_src == CLK_INTERNAL_FAST_RC_TICK);
  always_comb begin
    unique case (i_opt_cycle_sel) // RQ17
      2'h0: o_cycle_div = CYCLE_DIV_2;
      2'h1: o_cycle_div = CYCLE_DIV_4;
      2'h2: o_cycle_div = CYCLE_DIV_8;
      default: o_cycle_div = CYCLE_DIV_16;
    endcase
  end
  wire wdt_enable_running = (i_opt_wdt == WDT_ENABLE) && !i_power_down;
  assign o_wdt_run = (i_opt_wdt == WDT_ALWAYS_ON) || wdt_enable_running; // RQ18

  // pin taken as synchronous; edge detect adds one cycle of latency
  // previous sample resets to the idle high level, so reset release is no edge
  wire pin_fell = pin_prev_r && !i_shared_pin;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pin_prev_r <= 1'b1;
      ext_reset_r <= 1'b0;
    end else begin
      pin_prev_r <= i_shared_pin;
      ext_reset_r <= i_opt_reset_pin && pin_fell; // RQ19
    end
  end
  assign o_ext_reset = ext_reset_r;
  assign o_input_only_pin = !i_opt_reset_pin; // RQ20
  assign o_input_pullup_en = 1'b0; // RQ20
  assign o_rom_dump_block = i_opt_security && i_rom_external_dump; // RQ21
endmodule : core_pointer_stack_unit

// ===== testbench/core_ptr_chk.sv
// checker: port-level assertions for the pointer, table and stack unit
`timescale 1ns/1ps
module core_ptr_chk
  import core_ptr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic i_reg_imm,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic o_imm_refused,
  input wire logic [15:0] o_ram_addr,
  input wire logic i_call_push,
  input wire logic i_irq_push,
  input wire logic i_sub_exit,
  input wire logic i_irq_exit,
  input wire logic o_pop_valid,
  input wire logic o_global_irq_enable,
  input wire logic i_rom_table_read,
  input wire logic [15:0] i_rom_data,
  input wire logic [7:0] o_acc_data,
  input wire logic o_acc_load,
  input wire logic i_rom_external_dump,
  input wire logic i_opt_security,
  input wire logic o_rom_dump_block,
  input wire logic [1:0] i_opt_cycle_sel,
  input wire logic [4:0] o_cycle_div,
  input wire wdt_mode_e i_opt_wdt,
  input wire logic i_power_down,
  input wire logic o_wdt_run,
  input wire logic i_opt_reset_pin,
  input wire logic i_shared_pin,
  input wire logic o_ext_reset
);
  // ==========================================================
  // helpers and assertions
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  wire logic push_any = i_call_push | i_irq_push;
  wire logic pop_any = i_sub_exit | i_irq_exit;
  wire logic [7:0] rom_low = i_rom_data[7:0];
  wire logic gie_in = i_reg_wdata[7];
  a_pop_answer: assert property (pop_any && !push_any |=> o_pop_valid)
    else $error("pop not answered");
  a_table_low: assert property (i_rom_table_read |=> o_acc_load && o_acc_data == $past(rom_low))
    else $error("table low byte wrong");
  a_imm_refuse: assert property (i_reg_we && i_reg_imm |-> o_imm_refused == (i_reg_addr < 8'h80 || i_reg_addr > 8'h87))
    else $error("immediate refusal wrong");
  a_direct_map: assert property ((i_reg_we || i_reg_re) && !i_reg_imm && i_reg_addr < 8'h80 |-> o_ram_addr == {8'h00, i_reg_addr})
    else $error("direct address wrong");
  a_gie_write: assert property (i_reg_we && !i_reg_imm && i_reg_addr == 8'hDF && !push_any && !pop_any |=> o_global_irq_enable == $past(gie_in))
    else $error("irq enable not written");
  a_dump_block: assert property (o_rom_dump_block == (i_opt_security && i_rom_external_dump))
    else $error("dump block wrong");
  a_cycle_div: assert property (o_cycle_div == 5'h02 << i_opt_cycle_sel)
    else $error("cycle divider wrong");
  a_wdt_run: assert property (o_wdt_run == (i_opt_wdt == WDT_ALWAYS_ON || (i_opt_wdt == WDT_ENABLE && !i_power_down)))
    else $error("watchdog run wrong");
  a_pin_reset: assert property (i_opt_reset_pin && $fell(i_shared_pin) |-> ##[0:2] o_ext_reset)
    else $error("pin reset missing");
endmodule : core_ptr_chk

// ===== testbench/tb.sv
// testbench: directed scenarios for the pointer, table and stack unit
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  import core_ptr_pkg::*;
  // ==========================================================
  // signals
  logic i_mclk = 1'b0, i_srst = 1'b1, i_reg_we = 1'b0, i_reg_re = 1'b0, i_reg_imm = 1'b0;
  logic i_call_push = 1'b0, i_irq_push = 1'b0, i_sub_exit = 1'b0, i_irq_exit = 1'b0;
  logic i_rom_table_read = 1'b0, i_rom_external_dump = 1'b0, i_opt_reset_pin = 1'b1;
  logic i_opt_security = 1'b0, i_power_down = 1'b0, i_shared_pin = 1'b1;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_ram_rdata = 8'h5A;
  logic [13:0] i_pc = 14'h0000;
  logic [15:0] i_rom_data = 16'hBEEF;
  logic [1:0] i_opt_cycle_sel = 2'h0;
  clk_src_e i_opt_clk_src = CLK_INTERNAL_FAST_RC;
  wdt_mode_e i_opt_wdt = WDT_ALWAYS_ON;
  logic [7:0] o_reg_rdata, o_ram_wdata, o_acc_data, rd;
  logic [15:0] o_ram_addr, o_rom_addr, ra;
  logic [13:0] o_pop_pc, pp;
  logic o_imm_refused, o_ram_we, o_ram_re, o_pop_valid, o_stack_overflow, o_global_irq_enable;
  logic o_acc_load, o_osc_pins_gpio, o_xout_gpio, o_rtc_tick_en, o_wdt_run, o_ext_reset;
  logic o_input_only_pin, o_input_pullup_en, o_rom_dump_block, rwe, rre, rref, pv, seen;
  logic [4:0] o_cycle_div;
  int failures = 0, check_count = 0;
  core_pointer_stack_unit DUT (.*);
  always #50 i_mclk = ~i_mclk;
  // ==========================================================
  // drivers: inputs move 1 ns after the edge so sampling never races
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask : tick
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic imm);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_we = w;
    i_reg_re = !w;
    i_reg_imm = imm;
    #10 {rd, ra, rwe, rre, rref} = {o_reg_rdata, o_ram_addr, o_ram_we, o_ram_re, o_imm_refused};
    tick();
  endtask : bus
  task automatic stop();
    i_reg_we = 1'b0;
    i_reg_re = 1'b0;
    i_reg_imm = 1'b0;
    tick();
  endtask : stop
  // op bits: call push, irq push, sub exit, irq exit; idle cycle after keeps strobes apart
  task automatic stk(input logic [13:0] pc, input logic [3:0] op);
    i_pc = pc;
    {i_call_push, i_irq_push, i_sub_exit, i_irq_exit} = op;
    tick();
    {i_call_push, i_irq_push, i_sub_exit, i_irq_exit} = 4'h0;
    {pv, pp} = {o_pop_valid, o_pop_pc};
    tick();
  endtask : stk
  // ==========================================================
  // scenarios
  task automatic t_reset();
    bus(ADDR_STACK_PTR_CTL, 1'b0, 8'h00, 1'b0);
    `CHK(rd & 8'h87, 8'h07)
    bus(8'hF0, 1'b0, 8'h00, 1'b0);
    `CHK(rd, 8'h00)
    bus(8'hFF, 1'b0, 8'h00, 1'b0);
    `CHK(rd, 8'h00)
    stop();
    `CHK({o_global_irq_enable, o_stack_overflow}, 2'b00)
    $display("reset test done");
  endtask : t_reset
  task automatic t_pointers();
    bus(ADDR_FIRST_PTR_HIGH, 1'b1, 8'h00, 1'b1);
    bus(ADDR_FIRST_PTR_LOW, 1'b1, 8'h20, 1'b1);
    bus(ADDR_SECOND_PTR_HIGH, 1'b1, 8'h03, 1'b0);
    bus(ADDR_SECOND_PTR_LOW, 1'b1, 8'h25, 1'b1);
    bus(ADDR_FIRST_PTR_LOW, 1'b0, 8'h00, 1'b0);
    `CHK(rd, 8'h20)
    bus(ADDR_FIRST_WINDOW, 1'b0, 8'h00, 1'b0);
    `CHK({ra, rre, rd}, {16'h0020, 1'b1, 8'h5A})
    bus(ADDR_SECOND_WINDOW, 1'b1, 8'hC3, 1'b0);
    `CHK({ra, rwe, o_ram_wdata}, {16'h0325, 1'b1, 8'hC3})
    bus(8'h88, 1'b1, 8'h11, 1'b1);
    `CHK(rref, 1'b1)
    bus(ADDR_TABLE_HIGH, 1'b1, 8'h3C, 1'b1);
    `CHK(rref, 1'b0)
    bus(8'h12, 1'b1, 8'hA5, 1'b0);
    `CHK({ra, rwe, o_ram_wdata}, {16'h0012, 1'b1, 8'hA5})
    bus(8'h12, 1'b0, 8'h00, 1'b0);
    `CHK({ra, rre, rd}, {16'h0012, 1'b1, 8'h5A})
    bus(ADDR_TABLE_HIGH, 1'b0, 8'h00, 1'b0);
    `CHK(rd, 8'h3C)
    stop();
    $display("pointer test done");
  endtask : t_pointers
  task automatic t_table();
    bus(ADDR_SECOND_PTR_HIGH, 1'b1, 8'h12, 1'b0);
    bus(ADDR_SECOND_PTR_LOW, 1'b1, 8'h34, 1'b0);
    stop();
    `CHK(o_rom_addr, 16'h1234)
    i_rom_table_read = 1'b1;
    tick();
    i_rom_table_read = 1'b0;
    `CHK({o_acc_load, o_acc_data}, {1'b1, 8'hEF})
    bus(ADDR_TABLE_HIGH, 1'b0, 8'h00, 1'b0);
    `CHK(rd, 8'hBE)
    stop();
    $display("table test done");
  endtask : t_table
  task automatic t_stack();
    bus(ADDR_STACK_PTR_CTL, 1'b1, 8'h07, 1'b0);
    stop();
    for (int i = 0; i < 8; i++) begin
      stk(14'h3A11 + 14'(i * 65), {!i[0], i[0], 2'b00});
      bus(ADDR_STACK_PTR_CTL, 1'b0, 8'h00, 1'b0);
      stop();
      `CHK(rd[2:0], 3'(6 - i))
    end
    bus(8'hFF, 1'b0, 8'h00, 1'b0);
    `CHK(rd, 8'h3A)
    bus(8'hF0, 1'b0, 8'h00, 1'b0);
    `CHK(rd, 8'hD8)
    stop();
    for (int i = 7; i >= 0; i--) begin
      stk(14'h0000, {2'b00, i[0], !i[0]});
      `CHK({pv, pp}, {1'b1, 14'h3A11 + 14'(i * 65)})
    end
    for (int i = 0; i < 9; i++) begin
      stk(14'h0001, 4'h8);
      `CHK(o_stack_overflow, 1'(i == 8))
    end
    bus(ADDR_STACK_PTR_CTL, 1'b1, 8'h87, 1'b0);
    stop();
    `CHK({o_global_irq_enable, o_stack_overflow}, 2'b10)
    $display("stack test done");
  endtask : t_stack
  task automatic t_options();
    for (int c = 0; c < 4; c++) begin
      i_opt_cycle_sel = 2'(c);
      tick();
      `CHK(o_cycle_div, 5'h02 << c)
    end
    for (int s = 0; s < 6; s++) begin
      i_opt_clk_src = clk_src_e'(s);
      tick();
      `CHK({o_osc_pins_gpio, o_xout_gpio, o_rtc_tick_en}, {s < 2, s < 3, s == 1})
    end
    for (int m = 0; m < 6; m++) begin
      i_opt_wdt = wdt_mode_e'(m / 2);
      i_power_down = m[0];
      tick();
      `CHK(o_wdt_run, m < 3)
    end
    for (int k = 0; k < 4; k++) begin
      {i_opt_security, i_rom_external_dump} = 2'(k);
      tick();
      `CHK(o_rom_dump_block, k == 3)
    end
    tick();
    for (int p = 0; p < 2; p++) begin
      i_opt_reset_pin = 1'(1 - p);
      i_shared_pin = 1'b0;
      seen = 1'b0;
      repeat (4) begin
        tick();
        seen = seen | o_ext_reset;
      end
      `CHK({seen, o_input_only_pin, o_input_pullup_en}, {p == 0, p == 1, 1'b0})
      i_shared_pin = 1'b1;
      tick();
    end
    $display("option test done");
  endtask : t_options
  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #2_000_000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    t_reset();
    t_pointers();
    t_table();
    t_stack();
    t_options();
    report_and_stop();
  end
endmodule : tb
bind core_pointer_stack_unit core_ptr_chk chk (.*);
